// ===== hw/pmc_power_mode_controller.sv
// Purpose: light and deep sleep control with wake from interrupt or reset
// Assumes: srst is the reset pin level seen synchronously; irq inputs are
//          already synchronous to core_clk
// Notes:   cpu, peripheral and oscillator gating are enables for gate cells
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
module pmc_power_mode_controller
	import pmc_pkg::*;
#(
	parameter int IRQ_N = 7 // number of maskable interrupt sources
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	// avalon-mm slave
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	output logic      [1:0]       avs_response,
	// cpu side
	input  wire logic             cpu_instr_retire,
	input  wire logic [IRQ_N-1:0] irq_pending,
	input  wire logic             ext_wake_irq0_n,
	input  wire logic             ext_wake_irq1_n,
	output logic                  cpu_clk_en,
	output logic                  periph_clk_en,
	output logic                  osc_en,
	output logic                  cpu_hold,
	output logic                  cpu_reset_req,
	output logic                  ram_block,
	output logic                  port_allow
);

	pmc_state_e        state;       // power state
	pmc_state_e        next_state;  // next power state
	logic [PMC_CTRL_W-1:0] ctrl;    // power control register
	logic [7:0]        irq_en;      // global and per-source enables
	logic [3:0]        wait_cnt;    // settle and reset-run counter
	logic              arm;         // sleep request waiting for retire
	logic              ack;         // bus answer, one cycle
	logic              wake_light;  // light sleep wake condition
	logic              wake_ext;    // either external wake pin low
	logic              wr_ctrl;     // write to control register
	logic              rst_wake;    // reset pin while asleep

	// address match, shared by every register decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		return a == o;
	endfunction

	assign wake_light = irq_en[PMC_BIT_GLOBAL] &
		(|(irq_pending & irq_en[IRQ_N-1:0]));
	assign wake_ext   = ~ext_wake_irq0_n | ~ext_wake_irq1_n;
	assign wr_ctrl    = avs_write & ~ack & avs_byteenable[0] &
		hit(avs_address, PMC_OFS_CTRL);
	assign rst_wake   = srst & (state == PMC_LIGHT || state == PMC_DEEP);

	// bus handshake: answer on the second cycle of each request
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
		end
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign avs_response    = 2'h0;

	// read data, reserved bits zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & ~ack) begin
			if (hit(avs_address, PMC_OFS_CTRL)) begin
				avs_readdata <= {27'h0, ctrl};
			end else if (hit(avs_address, PMC_OFS_STATUS)) begin
				avs_readdata <= {29'h0, state};
			end else if (hit(avs_address, PMC_OFS_IRQEN)) begin
				avs_readdata <= {24'h0, irq_en};
			end else begin
				avs_readdata <= 32'h0; // unmapped reads as zero
			end
		end
	end

	// interrupt enable register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_en <= PMC_IRQEN_RST;
		end else if (avs_write & ~ack & avs_byteenable[0] &
				hit(avs_address, PMC_OFS_IRQEN)) begin
			irq_en <= avs_writedata[7:0];
		end
	end

	// power control register; hardware clear on wake
	always_ff @(posedge core_clk) begin
		if (srst) begin
			// reset pin clears every control bit: both mode bits, the general flags and pof
			ctrl <= PMC_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl <= avs_writedata[PMC_CTRL_W-1:0];
			end
			if (state == PMC_LIGHT && wake_light) begin
				ctrl[PMC_BIT_LIGHT] <= 1'b0;
			end
			if (state == PMC_DEEP && wake_ext) begin
				ctrl[PMC_BIT_DEEP]  <= 1'b0;
				ctrl[PMC_BIT_LIGHT] <= 1'b0;
			end
		end
	end

	// sleep request armed until the setting instruction retires
	always_ff @(posedge core_clk) begin
		if (srst) begin
			arm <= 1'b0;
		end else if (wr_ctrl) begin
			arm <= avs_writedata[PMC_BIT_LIGHT] | avs_writedata[PMC_BIT_DEEP];
		end else if (cpu_instr_retire) begin
			arm <= 1'b0;
		end
	end

	// next power state
	always_comb begin
		next_state = state;
		case (state)
			PMC_RUN: begin
				if (arm & cpu_instr_retire) begin
					// deep wins when both are set
					if (ctrl[PMC_BIT_DEEP]) begin
						next_state = PMC_DEEP;
					end else if (ctrl[PMC_BIT_LIGHT]) begin
						next_state = PMC_LIGHT;
					end
				end
			end
			PMC_LIGHT: begin
				if (wake_light) begin
					next_state = PMC_RUN;
				end
			end
			PMC_DEEP: begin
				if (wake_ext) begin
					next_state = PMC_OSC_WAIT;
				end
			end
			PMC_OSC_WAIT: begin
				if (wait_cnt == 4'(PMC_OSC_SETTLE_CYC - 1)) begin
					next_state = PMC_HOLD_RELEASE;
				end
			end
			PMC_HOLD_RELEASE: begin
				// never back to light sleep after deep
				if (!wake_ext) begin
					next_state = PMC_RUN;
				end
			end
			PMC_RST_RUN: begin
				if (wait_cnt == 4'(PMC_RST_RUN_CYC - 1)) begin
					next_state = PMC_RST_SEQ;
				end
			end
			PMC_RST_SEQ: begin
				next_state = PMC_RUN;
			end
			default: begin
				next_state = PMC_RUN;
			end
		endcase
	end

	// state register; reset pin asleep gives a short run first
	always_ff @(posedge core_clk) begin
		if (rst_wake) begin
			state <= PMC_RST_RUN;
		end else if (srst) begin
			state <= PMC_RUN;
		end else begin
			state <= next_state;
		end
	end

	// settle and reset-run counter
	always_ff @(posedge core_clk) begin
		if (srst || next_state != state) begin
			wait_cnt <= 4'h0;
		end else if (state == PMC_OSC_WAIT || state == PMC_RST_RUN) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// clock and cpu controls; gating freezes state, never clears it
	always_comb begin
		cpu_clk_en    = (state != PMC_LIGHT) && (state != PMC_DEEP);
		periph_clk_en = (state != PMC_DEEP);
		osc_en        = (state != PMC_DEEP);
		cpu_hold      = (state == PMC_OSC_WAIT) ||
			(state == PMC_HOLD_RELEASE);
		cpu_reset_req = (state == PMC_RST_SEQ);
		ram_block     = (state == PMC_RST_RUN);
		port_allow    = 1'b1;
	end

	// light and deep both imply clocks stopped for the cpu
	light_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_LIGHT) |-> (!cpu_clk_en && periph_clk_en && osc_en))
		else $error("light sleep gating wrong");
	deep_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP) |-> (!cpu_clk_en && !periph_clk_en && !osc_en))
		else $error("deep sleep gating wrong");
	deep_wins_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_RUN && arm && cpu_instr_retire && ctrl[PMC_BIT_DEEP])
		|=> (state == PMC_DEEP))
		else $error("deep sleep not taken");
	light_enter_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_RUN && arm && cpu_instr_retire && ctrl == 5'h01)
		|=> (state == PMC_LIGHT))
		else $error("light sleep not taken");
	light_wake_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_LIGHT && wake_light)
		|=> (state == PMC_RUN && !ctrl[PMC_BIT_LIGHT] && cpu_clk_en))
		else $error("light wake failed");
	deep_wake_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP && wake_ext)
		|=> (osc_en && cpu_hold && !ctrl[PMC_BIT_DEEP]))
		else $error("deep wake failed");
	hold_release_a: assert property (@(posedge core_clk) disable iff (srst)
		(cpu_hold && wake_ext) |=> cpu_hold)
		else $error("cpu ran before wake released");
	rst_run_a: assert property (@(posedge core_clk) disable iff (srst)
		$rose(ram_block) |-> ram_block [*4] ##1 cpu_reset_req)
		else $error("reset run window wrong");
	no_light_after_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_HOLD_RELEASE) |=> (state != PMC_LIGHT))
		else $error("light after deep");

	// reset pin checks run without disable, since the pin is the trigger
	// reset pin in light sleep: bits cleared, cpu clock back
	rst_light_a: assert property (@(posedge core_clk)
		(srst && state == PMC_LIGHT)
		|=> (state == PMC_RST_RUN && ctrl == 5'h00 && cpu_clk_en))
		else $error("reset in light sleep wrong");
	// reset pin in deep sleep: deep bit cleared, oscillator back
	rst_deep_a: assert property (@(posedge core_clk)
		(srst && state == PMC_DEEP)
		|=> (state == PMC_RST_RUN && !ctrl[PMC_BIT_DEEP] && osc_en))
		else $error("reset in deep sleep wrong");
	// reset sequence request is a single cycle, then normal run
	rst_seq_a: assert property (@(posedge core_clk) disable iff (srst)
		cpu_reset_req |=> (state == PMC_RUN && !cpu_reset_req))
		else $error("reset sequence not one cycle");
	// while ram is blocked the cpu runs and ports stay reachable
	ram_only_a: assert property (@(posedge core_clk) disable iff (srst)
		ram_block |-> (port_allow && cpu_clk_en))
		else $error("reset run blocks ports");
	// deep bit alone sends the cpu to deep sleep on retire
	deep_enter_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_RUN && arm && cpu_instr_retire && ctrl == 5'h02)
		|=> (state == PMC_DEEP))
		else $error("deep sleep not entered");
	// either pin alone is enough to leave deep sleep
	ext_wake_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP && (!ext_wake_irq0_n || !ext_wake_irq1_n))
		|=> (state == PMC_OSC_WAIT))
		else $error("external pin did not wake");
	// settle window is ten cycles; keep in step with the package count
	osc_settle_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP && wake_ext)
		|-> ##10 (state == PMC_OSC_WAIT) ##1 (state == PMC_HOLD_RELEASE))
		else $error("oscillator settle window wrong");
	// held pin keeps the cpu parked after the settle window
	pin_hold_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_HOLD_RELEASE && wake_ext) |=> (state == PMC_HOLD_RELEASE))
		else $error("left hold with pin still low");
	// released pin lets the cpu run on the next cycle
	pin_free_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_HOLD_RELEASE && !wake_ext) |=> (state == PMC_RUN && !cpu_hold))
		else $error("cpu not released");
	// clocks are all back once the oscillator has settled
	clocks_back_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_HOLD_RELEASE) |-> (osc_en && periph_clk_en && cpu_clk_en))
		else $error("clocks not restored");
	// deep wake also clears a light bit set together with it
	deep_no_light_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP && wake_ext) |=> !ctrl[PMC_BIT_LIGHT])
		else $error("light bit left after deep wake");
	// light sleep holds while no enabled request is pending
	light_keep_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_LIGHT && !wake_light) |=> (state == PMC_LIGHT))
		else $error("light sleep left without wake");
	// light sleep leaves the control flags untouched
	light_state_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_LIGHT && !wake_light && !avs_write) |=> $stable(ctrl))
		else $error("control changed in light sleep");
	// deep sleep keeps the control flags until a wake pin
	deep_state_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP && !wake_ext && !avs_write)
		|=> (state == PMC_DEEP && $stable(ctrl)))
		else $error("deep sleep state lost");
	// the general flags survive a pin wake from deep sleep
	deep_flags_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_DEEP && wake_ext && !avs_write)
		|=> (ctrl[PMC_CTRL_W-1:PMC_BIT_GF0] == $past(ctrl[PMC_CTRL_W-1:PMC_BIT_GF0])))
		else $error("flags lost on deep wake");
	// light wake clears only the light bit, flags kept
	light_flags_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == PMC_LIGHT && wake_light && !avs_write)
		|=> (ctrl[PMC_CTRL_W-1:PMC_BIT_DEEP] == $past(ctrl[PMC_CTRL_W-1:PMC_BIT_DEEP])))
		else $error("flags lost on light wake");
	// the oscillator only stops in deep sleep itself
	osc_run_a: assert property (@(posedge core_clk) disable iff (srst)
		(state != PMC_DEEP) |-> osc_en)
		else $error("oscillator stopped outside deep sleep");

endmodule

// ===== hw/pmc_pkg.sv
// Purpose: constants for the power mode controller
// Assumes: 32-bit Avalon-MM register window, word addressed in bytes
// Notes:   one clock, synchronous active-high reset
package pmc_pkg;
	// register byte offsets
	localparam logic [3:0] PMC_OFS_CTRL   = 4'h0; // power control register
	localparam logic [3:0] PMC_OFS_STATUS = 4'h4; // mode and wake status
	localparam logic [3:0] PMC_OFS_IRQEN  = 4'h8; // interrupt enables
	// power control register fields
	localparam int PMC_BIT_LIGHT = 0; // light sleep bit
	localparam int PMC_BIT_DEEP  = 1; // deep sleep bit
	localparam int PMC_BIT_GF0   = 2; // general flag 0
	localparam int PMC_BIT_GF1   = 3; // general flag 1
	localparam int PMC_BIT_POF   = 4; // power-off flag
	localparam int PMC_CTRL_W    = 5; // implemented control bits
	localparam logic [4:0] PMC_CTRL_RST = 5'h00; // control reset value
	// interrupt enable register: bit 7 global, bits 6..0 per source
	localparam int PMC_BIT_GLOBAL = 7;
	localparam logic [7:0] PMC_IRQEN_RST = 8'h00;
	// oscillator restart settle time and cycle count at 10 MHz
	localparam int PMC_CLK_NS       = 100;
	localparam int PMC_OSC_SETTLE_NS = 1000;
	localparam int PMC_OSC_SETTLE_CYC =
		(PMC_OSC_SETTLE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
	// reset-wake window: cycles the cpu may run before reset sequence
	localparam int PMC_RST_RUN_CYC = 4;
	// power states
	typedef enum logic [2:0] {
		PMC_RUN,
		PMC_LIGHT,
		PMC_DEEP,
		PMC_OSC_WAIT,
		PMC_HOLD_RELEASE,
		PMC_RST_RUN,
		PMC_RST_SEQ
	} pmc_state_e;
endpackage

// ===== dv/pmc_cpu_model.sv
// Purpose: cpu and wake-pin stand-in for the power mode controller
// Assumes: one instruction retires per cycle while the cpu clock runs and cpu_hold is low
// Notes:   wake pins are driven low for a fixed time, then released high
`timescale 1ns/1ns
module pmc_cpu_model
	import pmc_pkg::*;
#(
	parameter int HOLD_CYC = PMC_OSC_SETTLE_CYC + 6 // pin low time, beyond settle
) (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       cpu_clk_en,
	input  wire logic       cpu_hold,
	input  wire logic [1:0] wake_req,
	output logic            cpu_instr_retire,
	output logic            ext_wake_irq0_n,
	output logic            ext_wake_irq1_n
);
	logic [4:0] hold_cnt; // cycles left with a pin low
	logic [1:0] pin_low;  // which pin is pulled low

	// retire while clocked and cpu_hold is low; code after sleep entry does no port write
	always_ff @(posedge core_clk) begin
		cpu_instr_retire <= cpu_clk_en && !cpu_hold && !srst;
	end

	// level wake held past oscillator settle, then released
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hold_cnt <= 5'h00;
			pin_low  <= 2'h0;
		end else if (hold_cnt == 5'h00 && wake_req != 2'h0) begin
			hold_cnt <= 5'(HOLD_CYC);
			pin_low  <= wake_req;
		end else if (hold_cnt != 5'h00) begin
			hold_cnt <= hold_cnt - 5'h01;
			if (hold_cnt == 5'h01) begin
				pin_low <= 2'h0;
			end
		end
	end
	assign ext_wake_irq0_n = !pin_low[0];
	assign ext_wake_irq1_n = !pin_low[1];
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: avalon answers after one wait cycle, status reads the state code
// Notes:   bus answers are taken at the rising edge that sees waitrequest low
`timescale 1ns/1ns
module tb_top
	import pmc_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        srst     = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read  = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [6:0]  irq_pending = 7'h00;
	logic [1:0]  wake_req = 2'h0;
	logic [31:0] avs_readdata, rd, nrb, nrr, bad;
	logic [1:0]  avs_response;
	logic        avs_waitrequest, retire, w0_n, w1_n;
	logic        cpu_clk_en, periph_clk_en, osc_en, cpu_hold;
	logic        cpu_reset_req, ram_block, port_allow;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;

	pmc_power_mode_controller i_dut (.core_clk(core_clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .cpu_instr_retire(retire),
		.irq_pending(irq_pending), .ext_wake_irq0_n(w0_n), .ext_wake_irq1_n(w1_n),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
		.cpu_hold(cpu_hold), .cpu_reset_req(cpu_reset_req), .ram_block(ram_block),
		.port_allow(port_allow));
	pmc_cpu_model i_cpu (.core_clk(core_clk), .srst(srst), .cpu_clk_en(cpu_clk_en),
		.cpu_hold(cpu_hold), .wake_req(wake_req), .cpu_instr_retire(retire),
		.ext_wake_irq0_n(w0_n), .ext_wake_irq1_n(w1_n));

	// 10 MHz clock
	always #50 core_clk = ~core_clk;
	// hang guard, far above the expected run
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// one access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// poll the state code, bounded
	task automatic poll(input logic [31:0] st);
		for (int i = 0; i < 40; i++) begin
			bus(1'b0, PMC_OFS_STATUS, 32'h0);
			if (rd === st) break;
		end
		chk(rd, st);
	endtask

	task automatic wrap_up();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		// reset values, unmapped place reads zero
		for (int a = 0; a < 16; a += 4) begin
			bus(1'b0, 4'(a), 32'h0);
			chk(rd, 32'h0);
		end
		// write with lane 0 off is ignored
		avs_byteenable <= 4'hE;
		bus(1'b1, PMC_OFS_IRQEN, 32'hFF);
		avs_byteenable <= 4'hF;
		bus(1'b0, PMC_OFS_IRQEN, 32'h0);
		chk(rd, 32'h0);
		// light sleep: only an enabled request wakes
		bus(1'b1, PMC_OFS_IRQEN, 32'h81);
		bus(1'b1, PMC_OFS_CTRL, 32'h1D);
		poll(32'h1);
		chk({cpu_clk_en, periph_clk_en, osc_en}, 3'b011);
		irq_pending <= 7'h02;
		poll(32'h1);
		irq_pending <= 7'h03;
		poll(32'h0);
		irq_pending <= 7'h00;
		bus(1'b0, PMC_OFS_CTRL, 32'h0);
		chk(rd, 32'h1C);
		// deep sleep with both bits, woken by each pin
		for (int p = 1; p < 3; p++) begin
			bus(1'b1, PMC_OFS_CTRL, 32'h1F);
			poll(32'h2);
			chk({cpu_clk_en, periph_clk_en, osc_en}, 3'b000);
			wake_req <= 2'(p);
			@(posedge core_clk);
			wake_req <= 2'h0;
			poll(32'h3);
			chk({cpu_hold, osc_en}, 2'b11);
			poll(32'h0);
			chk({w1_n, w0_n}, 2'b11);
			bus(1'b0, PMC_OFS_CTRL, 32'h0);
			chk(rd, 32'h1C);
		end
		// reset pin during light, then deep sleep
		for (int m = 1; m < 3; m++) begin
			bus(1'b1, PMC_OFS_CTRL, 32'(m));
			poll(32'(m));
			srst <= 1'b1;
			@(posedge core_clk);
			srst <= 1'b0;
			nrb = 0;
			nrr = 0;
			bad = 0;
			repeat (12) @(negedge core_clk) begin
				nrb += ram_block;
				nrr += cpu_reset_req;
				if (ram_block && !(cpu_clk_en && osc_en && port_allow)) bad++;
			end
			chk(nrb, PMC_RST_RUN_CYC);
			chk(nrr, 32'h1);
			chk(bad, 32'h0);
			bus(1'b0, PMC_OFS_CTRL, 32'h0);
			chk(rd, 32'h0);
		end
		wrap_up();
	end
endmodule
